// File: hdl/sysref_regs_defs.svh
// Constants of the reference-delay and lane-swing register bank.
// Assumes inclusion by bare name from files under hdl/.
`ifndef SYSREF_REGS_DEFS_SVH
`define SYSREF_REGS_DEFS_SVH

// Register addresses as seen in the serial frame
`define PAGE_CTRL_ADDR         12'h0_012
`define DELAY_HI_ADDR          12'h0_03c
`define SWING_SEL_ADDR         12'h0_03d
`define DELAY_LO_ADDR          12'h0_05a

// Field positions
`define PAGE_SEL_BIT           2
`define DELAY_ON_BIT           6
`define DELAY_UPPER_MSB        1
`define DELAY_UPPER_LSB        0
`define DELAY_LOWER_MSB        7
`define DELAY_LOWER_LSB        5
`define SWING_MSB              2
`define SWING_LSB              0

// Reset values
`define PAGE_SEL_RESET         1'h0
`define DELAY_ON_RESET         1'h0
`define DELAY_UPPER_RESET      2'h0
`define DELAY_LOWER_RESET      3'h0
`define SWING_RESET            3'h0

// Delay decode, in picoseconds and codes
`define DELAY_FIRST_PS         10'h0_0af
`define DELAY_STEP_PS          10'h0_019
`define DELAY_FIRST_CODE       5'h08
`define DELAY_LAST_CODE        5'h03

// Serial frame layout
`define FRAME_BITS             5'h18
`define FRAME_ADDR_DONE        5'h10

`endif

// File: hdl/sysref_regs_pkg.sv
// Types shared by the serial front end and the register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package sysref_regs_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [11:0] reg_addr_t;
  typedef logic [9:0]  level_t;
endpackage

// File: hdl/reg_access_if.sv
// Write strobe and read path between serial front end and register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  import sysref_regs_pkg::*;
  logic      wr;
  logic      master;
  reg_addr_t addr;
  reg_byte_t wdata;
  reg_byte_t rdata;
  modport port (output wr, master, addr, wdata, input rdata);
  modport bank (input wr, master, addr, wdata, output rdata);
endinterface
`default_nettype wire

// File: hdl/serial_ctrl_port.sv
// Serial control port: 24-bit frames, rw, M, two spare bits, address, data.
// Assumes pins asynchronous to i_clock; sclk half period of 4 clocks or more.
`timescale 1ns/100ps
`default_nettype none
`include "sysref_regs_defs.svh"
module serial_ctrl_port (
  input  wire logic         i_clock,
  input  wire logic         i_reset_n,
  input  wire logic         i_sen_n,
  input  wire logic         i_sclk,
  input  wire logic         i_sdi,
  output logic              o_sdo,
  output logic              o_sdo_oe,
  reg_access_if.port        bus
);
  import sysref_regs_pkg::*;

  logic        sen_s1_q, sen_s2_q, sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic        sdi_s1_q, sdi_s2_q;
  logic [4:0]  cnt_q, cnt_d;
  logic [23:0] shift_q, shift_d;
  logic [7:0]  rsr_q, rsr_d;
  logic        load_q, load_d, fetch_q, fetch_d, wr_q, wr_d;
  logic        rw_q, rw_d, master_q, master_d, sdo_q, sdo_d, oe_q, oe_d;
  reg_addr_t   addr_q, addr_d;
  logic        rise, fall;

  assign rise = sclk_s2_q & ~sclk_s3_q;
  assign fall = ~sclk_s2_q & sclk_s3_q;

  always_comb begin
    cnt_d    = cnt_q;
    shift_d  = shift_q;
    rsr_d    = rsr_q;
    load_d   = 1'b0;
    fetch_d  = load_q;
    wr_d     = 1'b0;
    rw_d     = rw_q;
    master_d = master_q;
    addr_d   = addr_q;
    sdo_d    = sdo_q;
    oe_d     = oe_q;
    if (sen_s2_q) begin
      cnt_d = 5'h00;
      oe_d  = 1'b0;
    end else begin
      if (rise && cnt_q != `FRAME_BITS) begin
        shift_d = {shift_q[22:0], sdi_s2_q};
        cnt_d   = cnt_q + 5'h01;
        if (cnt_q == `FRAME_ADDR_DONE - 5'h01) begin
          load_d = 1'b1;
        end
        if (cnt_q == `FRAME_BITS - 5'h01 && !rw_q) begin
          wr_d = 1'b1;
        end
      end
      if (fall && rw_q && cnt_q >= `FRAME_ADDR_DONE
          && cnt_q < `FRAME_BITS) begin
        sdo_d = rsr_q[7];
        rsr_d = {rsr_q[6:0], 1'b0};
        oe_d  = 1'b1;
      end
    end
    // Header complete: latch direction, page and address
    if (load_q) begin
      rw_d     = shift_q[15];
      master_d = ~shift_q[14];
      addr_d   = shift_q[11:0];
    end
    if (fetch_q) begin
      rsr_d = bus.rdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sen_s1_q  <= 1'b1;
      sen_s2_q  <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sdi_s1_q  <= 1'b0;
      sdi_s2_q  <= 1'b0;
      cnt_q     <= 5'h00;
      shift_q   <= 24'h00_0000;
      rsr_q     <= 8'h00;
      load_q    <= 1'b0;
      fetch_q   <= 1'b0;
      wr_q      <= 1'b0;
      rw_q      <= 1'b0;
      master_q  <= 1'b0;
      addr_q    <= 12'h000;
      sdo_q     <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      sen_s1_q  <= i_sen_n;
      sen_s2_q  <= sen_s1_q;
      sclk_s1_q <= i_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdi_s1_q  <= i_sdi;
      sdi_s2_q  <= sdi_s1_q;
      cnt_q     <= cnt_d;
      shift_q   <= shift_d;
      rsr_q     <= rsr_d;
      load_q    <= load_d;
      fetch_q   <= fetch_d;
      wr_q      <= wr_d;
      rw_q      <= rw_d;
      master_q  <= master_d;
      addr_q    <= addr_d;
      sdo_q     <= sdo_d;
      oe_q      <= oe_d;
    end
  end

  assign bus.wr     = wr_q;
  assign bus.master = master_q;
  assign bus.addr   = addr_q;
  assign bus.wdata  = shift_q[7:0];
  assign o_sdo      = sdo_q;
  assign o_sdo_oe   = oe_q;
endmodule
`default_nettype wire

// File: hdl/sysref_delay_swing_regs.sv
// Reference-delay and lane-swing registers of the master page.
// Assumes a host on the serial control port; pins are asynchronous.
// Summary of operation
// R1 - Bit 6 of delay-high register enables the added reference delay.
// R2 - Delay code is upper bits 1-0 of high, lower bits 7-5 of low.
// R3 - Delay moves in 25 ps steps; first step is 175 ps.
// R4 - Code 01000 gives 175 ps, each decrement adds 25, 00011 gives 300.
// R5 - Swing bits 2-0 pick one of eight amplitudes for every lane.
// R6 - Host sets master page select before touching these registers.
// R7 - Unused bits are written zero and always held and read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "sysref_regs_defs.svh"
module sysref_delay_swing_regs (
  input  wire logic                      i_clock,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_sen_n,
  input  wire logic                      i_sclk,
  input  wire logic                      i_sdi,
  output logic                           o_sdo,
  output logic                           o_sdo_oe,
  output logic                           o_master_page_sel,
  output logic                           o_ref_delay_on,
  output logic [4:0]                     o_ref_delay_code,
  output logic                           o_ref_delay_valid,
  output sysref_regs_pkg::level_t        o_ref_delay_ps,
  output logic [2:0]                     o_lane_drive_amplitude_sel,
  output sysref_regs_pkg::level_t        o_lane_swing_mvpp
);
  import sysref_regs_pkg::*;

  reg_access_if bus ();

  serial_ctrl_port u_port (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_sen_n   (i_sen_n),
    .i_sclk    (i_sclk),
    .i_sdi     (i_sdi),
    .o_sdo     (o_sdo),
    .o_sdo_oe  (o_sdo_oe),
    .bus       (bus.port)
  );

  logic       page_sel_q, page_sel_d;
  logic       ref_delay_on_q, ref_delay_on_d;
  logic [1:0] ref_delay_code_upper_q, ref_delay_code_upper_d;
  logic [2:0] ref_delay_code_lower_q, ref_delay_code_lower_d;
  logic [2:0] lane_drive_amplitude_sel_q, lane_drive_amplitude_sel_d;
  logic       valid_q, valid_d;
  level_t     delay_ps_q, delay_ps_d;
  level_t     swing_mv_q, swing_mv_d;
  logic [4:0] code;
  logic [4:0] steps;
  logic       master_ok;
  reg_byte_t  rdata;

  assign code      = {ref_delay_code_upper_q, ref_delay_code_lower_q}; // R2
  assign steps     = `DELAY_FIRST_CODE - code;
  assign master_ok = page_sel_q & bus.master; // R6

  // Register writes; only field bits are stored
  always_comb begin
    page_sel_d                 = page_sel_q;
    ref_delay_on_d             = ref_delay_on_q;
    ref_delay_code_upper_d     = ref_delay_code_upper_q;
    ref_delay_code_lower_d     = ref_delay_code_lower_q;
    lane_drive_amplitude_sel_d = lane_drive_amplitude_sel_q;
    if (bus.wr && bus.addr == `PAGE_CTRL_ADDR) begin
      page_sel_d = bus.wdata[`PAGE_SEL_BIT];
    end
    if (bus.wr && master_ok) begin // R6
      unique case (bus.addr)
        `DELAY_HI_ADDR: begin
          ref_delay_on_d = bus.wdata[`DELAY_ON_BIT]; // R1
          ref_delay_code_upper_d =
            bus.wdata[`DELAY_UPPER_MSB:`DELAY_UPPER_LSB]; // R2
        end
        `DELAY_LO_ADDR: begin
          ref_delay_code_lower_d =
            bus.wdata[`DELAY_LOWER_MSB:`DELAY_LOWER_LSB]; // R2
        end
        `SWING_SEL_ADDR: begin
          lane_drive_amplitude_sel_d =
            bus.wdata[`SWING_MSB:`SWING_LSB]; // R5
        end
        default: begin
        end
      endcase
    end
  end

  // Read-back; unused positions always zero
  always_comb begin
    rdata = 8'h00; // R7
    if (bus.addr == `PAGE_CTRL_ADDR) begin
      rdata[`PAGE_SEL_BIT] = page_sel_q;
    end else if (master_ok) begin
      unique case (bus.addr)
        `DELAY_HI_ADDR: begin
          rdata[`DELAY_ON_BIT] = ref_delay_on_q;
          rdata[`DELAY_UPPER_MSB:`DELAY_UPPER_LSB] = ref_delay_code_upper_q;
        end
        `DELAY_LO_ADDR: begin
          rdata[`DELAY_LOWER_MSB:`DELAY_LOWER_LSB] = ref_delay_code_lower_q;
        end
        `SWING_SEL_ADDR: begin
          rdata[`SWING_MSB:`SWING_LSB] = lane_drive_amplitude_sel_q;
        end
        default: begin
        end
      endcase
    end
  end
  assign bus.rdata = rdata;

  // Decode of delay and amplitude
  always_comb begin
    valid_d    = 1'b0;
    delay_ps_d = 10'h000;
    if (ref_delay_on_q && code <= `DELAY_FIRST_CODE
        && code >= `DELAY_LAST_CODE) begin // R1
      valid_d    = 1'b1;
      delay_ps_d = `DELAY_FIRST_PS
                 + 10'(steps) * `DELAY_STEP_PS; // R3 R4
    end
    unique case (lane_drive_amplitude_sel_q) // R5
      3'h0: swing_mv_d = 10'd860;
      3'h1: swing_mv_d = 10'd810;
      3'h2: swing_mv_d = 10'd770;
      3'h3: swing_mv_d = 10'd745;
      3'h4: swing_mv_d = 10'd960;
      3'h5: swing_mv_d = 10'd930;
      3'h6: swing_mv_d = 10'd905;
      3'h7: swing_mv_d = 10'd880;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      page_sel_q                 <= `PAGE_SEL_RESET;
      ref_delay_on_q             <= `DELAY_ON_RESET;
      ref_delay_code_upper_q     <= `DELAY_UPPER_RESET;
      ref_delay_code_lower_q     <= `DELAY_LOWER_RESET;
      lane_drive_amplitude_sel_q <= `SWING_RESET;
      valid_q                    <= 1'b0;
      delay_ps_q                 <= 10'h000;
      swing_mv_q                 <= 10'd860;
    end else begin
      page_sel_q                 <= page_sel_d;
      ref_delay_on_q             <= ref_delay_on_d;
      ref_delay_code_upper_q     <= ref_delay_code_upper_d;
      ref_delay_code_lower_q     <= ref_delay_code_lower_d;
      lane_drive_amplitude_sel_q <= lane_drive_amplitude_sel_d;
      valid_q                    <= valid_d;
      delay_ps_q                 <= delay_ps_d;
      swing_mv_q                 <= swing_mv_d;
    end
  end

  assign o_master_page_sel          = page_sel_q;
  assign o_ref_delay_on             = ref_delay_on_q;
  assign o_ref_delay_code           = code;
  assign o_ref_delay_valid          = valid_q;
  assign o_ref_delay_ps             = delay_ps_q;
  assign o_lane_drive_amplitude_sel = lane_drive_amplitude_sel_q;
  assign o_lane_swing_mvpp          = swing_mv_q;

  delay_off_a: assert property ( // R1
    @(posedge i_clock) disable iff (!i_reset_n)
    !ref_delay_on_q |=> o_ref_delay_ps == 10'd0 && !o_ref_delay_valid)
    else $error("delay present while disabled");

  code_split_a: assert property ( // R2
    @(posedge i_clock) disable iff (!i_reset_n)
    bus.wr && master_ok && bus.addr == `DELAY_LO_ADDR
    |=> o_ref_delay_code[2:0] == $past(bus.wdata[7:5])
        && $stable(o_ref_delay_code[4:3]))
    else $error("lower code bits not taken from bits 7-5");

  first_step_a: assert property ( // R3
    @(posedge i_clock) disable iff (!i_reset_n)
    ref_delay_on_q && code == 5'h08 |=> o_ref_delay_ps == 10'd175)
    else $error("first step is not 175 ps");

  delay_decode_a: assert property ( // R4
    @(posedge i_clock) disable iff (!i_reset_n)
    ref_delay_on_q && code >= 5'h03 && code <= 5'h08
    |=> o_ref_delay_valid
        && o_ref_delay_ps == 10'd175 + 10'd25 * (10'd8 - 10'($past(code)))
        ##1 1'b1)
    else $error("delay code decoded wrongly");

  swing_map_a: assert property ( // R5
    @(posedge i_clock) disable iff (!i_reset_n)
    lane_drive_amplitude_sel_q == 3'h4 ##1 lane_drive_amplitude_sel_q == 3'h4
    |-> o_lane_swing_mvpp == 10'd960)
    else $error("amplitude 4 is not 960 mVpp");

  zero_bits_a: assert property ( // R7
    @(posedge i_clock) disable iff (!i_reset_n)
    (bus.addr == `DELAY_HI_ADDR |-> (rdata & 8'hbc) == 8'h00)
    and (bus.addr == `DELAY_LO_ADDR |-> rdata[4:0] == 5'h00)
    and (bus.addr == `SWING_SEL_ADDR |-> rdata[7:3] == 5'h00))
    else $error("unused bits not zero");

  refused_write_a: assert property ( // R6
    @(posedge i_clock) disable iff (!i_reset_n)
    bus.wr && !master_ok && bus.addr == `DELAY_HI_ADDR
    |=> $stable(o_ref_delay_on) && $stable(o_ref_delay_code))
    else $error("delay register written outside master page");

  cover_write_hi_c: cover property (
    @(posedge i_clock) disable iff (!i_reset_n)
    bus.wr && master_ok && bus.addr == `DELAY_HI_ADDR);
  cover_max_delay_c: cover property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_ref_delay_ps == 10'd300);
  cover_read_c: cover property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_sdo_oe ##1 !o_sdo_oe);
  cover_refused_c: cover property (
    @(posedge i_clock) disable iff (!i_reset_n)
    bus.wr && !master_ok && bus.addr == `DELAY_HI_ADDR);
  cover_max_swing_c: cover property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_lane_swing_mvpp == 10'd960);
endmodule
`default_nettype wire

// File: sim/tb_sysref_delay_swing_regs.sv
// Self-checking bench for the reference-delay and lane-swing registers.
// Assumes the design files under hdl/; drives the serial pins directly.
`timescale 1ns/100ps
`default_nettype none
`include "sysref_regs_defs.svh"
module tb_sysref_delay_swing_regs;
  import sysref_regs_pkg::*;
  logic       i_clock;
  logic       i_reset_n;
  logic       i_sen_n;
  logic       i_sclk;
  logic       i_sdi;
  logic       o_sdo;
  logic       o_sdo_oe;
  logic       o_master_page_sel;
  logic       o_ref_delay_on;
  logic [4:0] o_ref_delay_code;
  logic       o_ref_delay_valid;
  level_t     o_ref_delay_ps;
  logic [2:0] o_lane_drive_amplitude_sel;
  level_t     o_lane_swing_mvpp;
  int         fails;
  int         compares;
  logic [7:0] v;
  logic [4:0] cv;
  int         exp_ps;
  level_t     swing_tab [8] = '{10'h35c, 10'h32a, 10'h302, 10'h2e9,
                                10'h3c0, 10'h3a2, 10'h389, 10'h370};

  sysref_delay_swing_regs dut_u (
    .i_clock                    (i_clock),
    .i_reset_n                  (i_reset_n),
    .i_sen_n                    (i_sen_n),
    .i_sclk                     (i_sclk),
    .i_sdi                      (i_sdi),
    .o_sdo                      (o_sdo),
    .o_sdo_oe                   (o_sdo_oe),
    .o_master_page_sel          (o_master_page_sel),
    .o_ref_delay_on             (o_ref_delay_on),
    .o_ref_delay_code           (o_ref_delay_code),
    .o_ref_delay_valid          (o_ref_delay_valid),
    .o_ref_delay_ps             (o_ref_delay_ps),
    .o_lane_drive_amplitude_sel (o_lane_drive_amplitude_sel),
    .o_lane_swing_mvpp          (o_lane_swing_mvpp)
  );

  always #4 i_clock = ~i_clock;

  task automatic ticks(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One 24-bit frame; sclk half period of 5 clocks, data set while low
  task automatic frame(input logic rw, input logic m, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] rdata);
    logic [23:0] bits;
    bits = {rw, m, 2'b00, a, d};
    rdata = 8'h00;
    @(posedge i_clock);
    i_sen_n <= 1'b0;
    ticks(5);
    for (int i = 23; i >= 0; i--) begin
      i_sdi <= bits[i];
      ticks(5);
      if (i < 8) begin
        rdata[i] = o_sdo;
        check(o_sdo_oe, rw);
      end
      i_sclk <= 1'b1;
      ticks(5);
      i_sclk <= 1'b0;
    end
    ticks(5);
    i_sen_n <= 1'b1;
    ticks(10);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    frame(1'b0, 1'b0, a, d, x);
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    frame(1'b1, 1'b0, a, 8'h00, d);
  endtask

  initial begin
    i_clock = 1'b0;
    i_reset_n = 1'b0;
    i_sen_n = 1'b1;
    i_sclk = 1'b0;
    i_sdi = 1'b0;
    fails = 0;
    compares = 0;
    ticks(8);
    i_reset_n <= 1'b1;
    ticks(4);
    check(o_ref_delay_ps, 16'h0000);
    check(o_lane_swing_mvpp, 16'h035c);
    check({o_ref_delay_on, o_ref_delay_code}, 16'h0000);
    // Master page not yet selected: access refused
    wr(`DELAY_HI_ADDR, 8'h42);
    check(o_ref_delay_on, 16'h0000);
    rd(`DELAY_HI_ADDR, v);
    check(v, 16'h0000);
    wr(`PAGE_CTRL_ADDR, 8'h04);
    check(o_master_page_sel, 16'h0001);
    rd(`PAGE_CTRL_ADDR, v);
    check(v, 16'h0004);
    frame(1'b0, 1'b1, `DELAY_HI_ADDR, 8'h42, v);
    check(o_ref_delay_on, 16'h0000);
    // All ones: unused bits dropped
    wr(`DELAY_HI_ADDR, 8'hff);
    rd(`DELAY_HI_ADDR, v);
    check(v, 16'h0043);
    check(o_ref_delay_code, 16'h0018);
    check(o_ref_delay_ps, 16'h0000);
    wr(`DELAY_LO_ADDR, 8'hff);
    rd(`DELAY_LO_ADDR, v);
    check(v, 16'h00e0);
    check(o_ref_delay_code, 16'h001f);
    // Codes around the decoded span
    for (int c = 9; c >= 2; c--) begin
      cv = c[4:0];
      wr(`DELAY_HI_ADDR, {6'h10, cv[4:3]});
      wr(`DELAY_LO_ADDR, {cv[2:0], 5'h00});
      exp_ps = (c >= 3 && c <= 8) ? 175 + (8 - c) * 25 : 0;
      check(o_ref_delay_code, {11'h000, cv});
      check(o_ref_delay_valid, 16'(c >= 3 && c <= 8));
      check(o_ref_delay_ps, 16'(exp_ps));
    end
    // Enable off with a legal code
    wr(`DELAY_LO_ADDR, 8'h00);
    wr(`DELAY_HI_ADDR, 8'h01);
    check(o_ref_delay_on, 16'h0000);
    check(o_ref_delay_code, 16'h0008);
    check(o_ref_delay_ps, 16'h0000);
    check(o_ref_delay_valid, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      wr(`SWING_SEL_ADDR, {5'h1f, s[2:0]});
      check(o_lane_drive_amplitude_sel, 16'(s));
      check(o_lane_swing_mvpp, swing_tab[s]);
    end
    rd(`SWING_SEL_ADDR, v);
    check(v, 16'h0007);
    rd(12'h0ff, v);
    check(v, 16'h0000);
    finish_test();
  end

  initial begin
    ticks(50000);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
